// File: rsq_consts.svh
`ifndef RSQ_CONSTS_SVH
`define RSQ_CONSTS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define RSQ_ADDR_SYNC 4'h0
`define RSQ_ADDR_SENSE 4'h1
`define RSQ_ADDR_GAIN 4'h2
`define RSQ_ADDR_FILTER 4'h3
`define RSQ_ADDR_BASE 4'h4
`define RSQ_ADDR_MOD 4'h5
`define RSQ_ADDR_DEPTH 4'h6
`define RSQ_ADDR_SHAPE 4'h7
`define RSQ_ADDR_PIN 4'h8
`define RSQ_ADDR_STATUS 4'h9
`define RSQ_ADDR_STRENGTH 4'hA
`define RSQ_ADDR_PQCOUNT 4'hB

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSQ_F_MODE 2:0
`define RSQ_F_PQT 6:4
`define RSQ_F_APPEND 7
`define RSQ_F_ABSOFS 3:0
`define RSQ_F_RELSTEP 5:4
`define RSQ_F_ABSEN 6
`define RSQ_F_FRONT 2:0
`define RSQ_F_DIGITAL 4:3
`define RSQ_F_TARGET 7:5
`define RSQ_F_FLEN 1:0
`define RSQ_F_FORMAT 1:0
`define RSQ_F_PINSEL 5:0
`define RSQ_S_CS 6
`define RSQ_S_PQ 5
`define RSQ_S_SYNC 3

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RSQ_RST_MODE 3'h2
`define RSQ_RST_BASE 8'hC0
`define RSQ_RST_TARGET 3'h3
`define RSQ_RST_SHAPE 8'h10
`define RSQ_PIN_PQ 6'h08
`define RSQ_PIN_CS 6'h0E
`define RSQ_FMT_FSK 2'h0
`define RSQ_FMT_OOK 2'h1
`define RSQ_FMT_ASK 2'h2
`define RSQ_REL_OFF 2'h0
`define RSQ_REL_6DB 2'h1
`define RSQ_REL_10DB 2'h2
`define RSQ_STEP_6DB 10'h00C
`define RSQ_STEP_10DB 10'h014
`define RSQ_STEP_14DB 10'h01C
`define RSQ_HYST 10'h004
`define RSQ_PQ_DROP 4'h8
`define RSQ_ERR16_MAX 5'h01
`define RSQ_ERR32_MAX 6'h02
`define RSQ_PA_FULL 8'hFF

`endif

// File: rsq_pkg.sv
package rsq_pkg;
    // Receive qualifier states
    typedef enum logic [1:0] {
        RSQ_IDLE,
        RSQ_SEARCH,
        RSQ_LOCKED
    } rsq_rx_e;

    typedef logic [7:0] rsq_byte_t;
    typedef logic [3:0] rsq_addr_t;
endpackage

// File: rsq_meter_if.sv
`timescale 1ns/100ps
`default_nettype none

// Strength samples from the meter to the qualifier logic
interface rsq_meter_if;
    logic signed [7:0] sample;
    logic sampleValid;
    logic [1:0] filterLength;

    modport meter (output sample, output sampleValid, input filterLength);
    modport user (input sample, input sampleValid, output filterLength);
endinterface

`default_nettype wire

// File: rsq_strength_meter.sv
`timescale 1ns/100ps
`default_nettype none

module rsq_strength_meter #(
    parameter int MAX_LEN = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Raw level samples at twice the channel bandwidth
    input wire logic signed [7:0] rawStrength,
    input wire logic rawStrengthValid,
    // Averaged samples out
    rsq_meter_if.meter mtr
);
    import rsq_pkg::*;

    localparam int CNT_W = 3 + MAX_LEN;
    localparam int SUM_W = 8 + CNT_W;

    initial begin
        if (MAX_LEN < 0 || MAX_LEN > 3) begin
            $error("MAX_LEN must lie in 0..3");
        end
    end

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic signed [SUM_W-1:0] sum;
        logic signed [7:0] sample;
        logic sampleValid;
    } rsq_meter_s;

    rsq_meter_s s;
    rsq_meter_s next_s;

    logic signed [SUM_W-1:0] total;
    logic [CNT_W-1:0] lastIndex;

    // ----------------------------------------
    // Averaging window of 8 * 2^length samples
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.sampleValid = 1'h0;
        total = s.sum + SUM_W'(rawStrength);
        lastIndex = CNT_W'((32'h8 << mtr.filterLength) - 32'h1);
        if (rawStrengthValid) begin
            if (s.count >= lastIndex) begin
                next_s.sample = 8'(total >>> (3 + mtr.filterLength));
                next_s.sampleValid = 1'h1;
                next_s.count = '0;
                next_s.sum = '0;
            end else begin
                next_s.count = s.count + CNT_W'(1);
                next_s.sum = total;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign mtr.sample = s.sample;
    assign mtr.sampleValid = s.sampleValid;

endmodule

`default_nettype wire

// File: rsq_rx_signal_qualifiers.sv
// The register addresses and the address-and-strobe port are this design's own decisions.
`include "rsq_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module rsq_rx_signal_qualifiers #(
    parameter int PQ_W = 6,
    parameter int MAX_LEN = 3
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port
    input wire rsq_pkg::rsq_addr_t regAddr,
    input wire rsq_pkg::rsq_byte_t regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output var rsq_pkg::rsq_byte_t regRdata,
    // Demodulator side
    input wire logic rxActive,
    input wire logic rxBit,
    input wire logic rxBitStrobe,
    input wire logic [4:0] syncErr16,
    input wire logic [5:0] syncErr32,
    input wire logic signed [7:0] rawStrength,
    input wire logic rawStrengthValid,
    input wire rsq_pkg::rsq_byte_t rxByte,
    input wire logic rxByteValid,
    input wire logic payloadDone,
    // Packet handler side
    output logic fifoWrite,
    output rsq_pkg::rsq_byte_t fifoData,
    output logic filterEnable,
    output logic syncFound,
    output logic statusByteValid,
    output rsq_pkg::rsq_byte_t statusByte,
    // Qualifier outputs
    output logic carrierSense,
    output logic preambleQualityReached,
    output logic generalOutputPin,
    // Gain loop limits
    output logic [2:0] maxFrontGain,
    output logic [1:0] maxDigitalGain,
    output logic [2:0] channelLevelTarget,
    // Transmit amplitude path
    input wire logic txActive,
    input wire logic txBit,
    output logic paEnable,
    output rsq_pkg::rsq_byte_t paLevel
);
    import rsq_pkg::*;

    initial begin
        if (PQ_W < 5 || PQ_W > 16) begin
            $error("PQ_W must lie in 5..16");
        end
    end

    typedef struct packed {
        logic [2:0] syncMode, pqThr, frontGain, levelTarget;
        logic appendStatus, absEnable, rxActiveQ, prevBit, bitSeen, pqReached, absSense, relSense;
        logic carrierSense, prevValid, syncFound, fifoWrite, statusByteValid, generalOutputPin, paEnable;
        logic [3:0] absOffset;
        logic [1:0] relStep, digitalGain, filterLength, modFormat;
        logic [7:0] senseBase, askDepth, shapeStep, fifoData, statusByte, paLevel, regRdata;
        logic [5:0] pinSelect;
        rsq_rx_e rxState;
        logic [PQ_W-1:0] pqCount;
        logic signed [7:0] strength, lastStrength, prevSample;
    } rsq_state_s;

    rsq_state_s s;
    rsq_state_s next_s;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Sync word bit criterion for the low two mode bits
    function automatic logic sync_bits_ok(input logic [1:0] mode, input logic [4:0] e16,
                                          input logic [5:0] e32);
        logic ok;
        ok = 1'h0;
        case (mode)
            2'h0: ok = 1'h1;
            2'h1: ok = (e16 <= `RSQ_ERR16_MAX);
            2'h2: ok = (e16 == 5'h00);
            2'h3: ok = (e32 <= `RSQ_ERR32_MAX);
            default: ok = 1'h0;
        endcase
        return ok;
    endfunction

    // Sign extend a byte to the 10-bit compare width
    function automatic logic signed [9:0] ext10(input logic [7:0] v);
        return {{2{v[7]}}, v};
    endfunction

    // ----------------------------------------
    // Strength meter
    // ----------------------------------------
    rsq_meter_if mtr ();

    rsq_strength_meter #(
        .MAX_LEN(MAX_LEN)
    ) u_meter (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .rawStrength(rawStrength),
        .rawStrengthValid(rawStrengthValid),
        .mtr(mtr)
    );

    assign mtr.filterLength = s.filterLength;

    logic signed [9:0] absThr, absLow, sample10, delta;
    logic [9:0] relThr;
    logic rxEntry, syncEnabled, csGateOk, pqGateOk, nextAbs, nextRel;
    logic [PQ_W-1:0] pqLimit;
    logic [8:0] levelSum;
    logic [7:0] askTarget;

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_s = s;
        next_s.fifoWrite = 1'h0;
        next_s.statusByteValid = 1'h0;
        next_s.regRdata = 8'h00;
        next_s.rxActiveQ = rxActive;
        rxEntry = rxActive && !s.rxActiveQ;
        syncEnabled = (s.syncMode[1:0] != 2'h0);

        // Register writes
        if (regWrite) begin
            case (regAddr)
                `RSQ_ADDR_SYNC: begin
                    next_s.syncMode = regWdata[`RSQ_F_MODE];
                    next_s.pqThr = regWdata[`RSQ_F_PQT];
                    next_s.appendStatus = regWdata[`RSQ_F_APPEND];
                end
                `RSQ_ADDR_SENSE: begin
                    next_s.absOffset = regWdata[`RSQ_F_ABSOFS];
                    next_s.relStep = regWdata[`RSQ_F_RELSTEP];
                    next_s.absEnable = regWdata[`RSQ_F_ABSEN];
                end
                `RSQ_ADDR_GAIN: begin
                    next_s.frontGain = regWdata[`RSQ_F_FRONT];
                    next_s.digitalGain = regWdata[`RSQ_F_DIGITAL];
                    next_s.levelTarget = regWdata[`RSQ_F_TARGET];
                end
                `RSQ_ADDR_FILTER: next_s.filterLength = regWdata[`RSQ_F_FLEN];
                `RSQ_ADDR_BASE: next_s.senseBase = regWdata;
                `RSQ_ADDR_MOD: next_s.modFormat = regWdata[`RSQ_F_FORMAT];
                `RSQ_ADDR_DEPTH: next_s.askDepth = regWdata;
                `RSQ_ADDR_SHAPE: next_s.shapeStep = regWdata;
                `RSQ_ADDR_PIN: next_s.pinSelect = regWdata[`RSQ_F_PINSEL];
                default: ;
            endcase
        end

        // Register reads, data in the following cycle
        if (regRead) begin
            case (regAddr)
                `RSQ_ADDR_SYNC: next_s.regRdata = {s.appendStatus, s.pqThr, 1'h0, s.syncMode};
                `RSQ_ADDR_SENSE: next_s.regRdata = {1'h0, s.absEnable, s.relStep, s.absOffset};
                `RSQ_ADDR_GAIN: next_s.regRdata = {s.levelTarget, s.digitalGain, s.frontGain};
                `RSQ_ADDR_FILTER: next_s.regRdata = {6'h00, s.filterLength};
                `RSQ_ADDR_BASE: next_s.regRdata = s.senseBase;
                `RSQ_ADDR_MOD: next_s.regRdata = {6'h00, s.modFormat};
                `RSQ_ADDR_DEPTH: next_s.regRdata = s.askDepth;
                `RSQ_ADDR_SHAPE: next_s.regRdata = s.shapeStep;
                `RSQ_ADDR_PIN: next_s.regRdata = {2'h0, s.pinSelect};
                `RSQ_ADDR_STATUS: begin
                    next_s.regRdata[`RSQ_S_CS] = s.carrierSense;
                    next_s.regRdata[`RSQ_S_PQ] = s.pqReached;
                    next_s.regRdata[`RSQ_S_SYNC] = s.syncFound;
                end
                `RSQ_ADDR_STRENGTH: next_s.regRdata = s.strength;
                `RSQ_ADDR_PQCOUNT: next_s.regRdata = 8'(s.pqCount);
                default: next_s.regRdata = 8'h00;
            endcase
        end

        // Carrier sense thresholds in half-dB units
        absThr = ext10(s.senseBase) + {{5{s.absOffset[3]}}, s.absOffset, 1'h0};
        absLow = absThr - `RSQ_HYST;
        sample10 = ext10(mtr.sample);
        delta = sample10 - ext10(s.prevSample);
        case (s.relStep)
            `RSQ_REL_6DB: relThr = `RSQ_STEP_6DB;
            `RSQ_REL_10DB: relThr = `RSQ_STEP_10DB;
            default: relThr = `RSQ_STEP_14DB;
        endcase
        nextAbs = s.absSense;
        nextRel = s.relSense;
        if (mtr.sampleValid) begin
            if (sample10 > absThr) begin
                nextAbs = 1'h1;
            end else if (sample10 < absLow) begin
                nextAbs = 1'h0;
            end
            if (s.prevValid && delta >= $signed(relThr)) begin
                nextRel = 1'h1;
            end else if (s.prevValid && delta <= -$signed(relThr)) begin
                nextRel = 1'h0;
            end
            next_s.prevSample = mtr.sample;
            next_s.prevValid = 1'h1;
        end
        nextAbs = nextAbs && s.absEnable;
        nextRel = nextRel && (s.relStep != `RSQ_REL_OFF);
        next_s.absSense = nextAbs;
        next_s.relSense = nextRel;
        next_s.carrierSense = nextAbs || nextRel;

        // Strength reading and last packet value
        if (mtr.sampleValid && rxActive) begin
            if (!(syncEnabled && s.syncFound)) begin
                next_s.strength = mtr.sample;
            end
            next_s.lastStrength = mtr.sample;
        end

        // Preamble quality estimator
        pqLimit = PQ_W'({s.pqThr, 2'h0});
        if (rxBitStrobe && s.rxState == RSQ_SEARCH) begin
            next_s.prevBit = rxBit;
            next_s.bitSeen = 1'h1;
            if (s.bitSeen && rxBit != s.prevBit) begin
                if (s.pqCount != {PQ_W{1'h1}}) begin
                    next_s.pqCount = s.pqCount + PQ_W'(1);
                end
            end else if (s.bitSeen) begin
                if (s.pqCount > PQ_W'(`RSQ_PQ_DROP)) begin
                    next_s.pqCount = s.pqCount - PQ_W'(`RSQ_PQ_DROP);
                end else begin
                    next_s.pqCount = '0;
                end
            end
        end
        next_s.pqReached = (next_s.pqCount > pqLimit);

        // Sync qualification
        csGateOk = !s.syncMode[2] || s.carrierSense;
        pqGateOk = (s.pqThr == 3'h0) || s.pqReached;
        case (s.rxState)
            RSQ_IDLE: begin
                if (rxActive) begin
                    next_s.rxState = RSQ_SEARCH;
                end
            end
            RSQ_SEARCH: begin
                if (!rxActive) begin
                    next_s.rxState = RSQ_IDLE;
                end else if (!syncEnabled && csGateOk) begin
                    next_s.rxState = RSQ_LOCKED;
                    next_s.syncFound = 1'h1;
                end else if (syncEnabled && rxBitStrobe && csGateOk && pqGateOk
                             && sync_bits_ok(s.syncMode[1:0], syncErr16, syncErr32)) begin
                    next_s.rxState = RSQ_LOCKED;
                    next_s.syncFound = 1'h1;
                end
            end
            RSQ_LOCKED: begin
                if (!rxActive) begin
                    next_s.rxState = RSQ_IDLE;
                end
            end
            default: next_s.rxState = RSQ_IDLE;
        endcase

        // Reentry into receive restarts sync, preamble quality and the relative sense reference
        if (rxEntry) begin
            next_s.rxState = RSQ_SEARCH;
            next_s.syncFound = 1'h0;
            next_s.pqCount = '0;
            next_s.pqReached = 1'h0;
            next_s.bitSeen = 1'h0;
            next_s.prevValid = 1'h0;
        end

        // Received bytes pass only after qualification
        if (rxByteValid && s.syncFound && rxActive) begin
            next_s.fifoWrite = 1'h1;
            next_s.fifoData = rxByte;
        end
        if (payloadDone && s.appendStatus && s.syncFound) begin
            next_s.statusByteValid = 1'h1;
            next_s.statusByte = s.lastStrength;
        end

        // Output pin function
        case (next_s.pinSelect)
            `RSQ_PIN_PQ: next_s.generalOutputPin = next_s.pqReached;
            `RSQ_PIN_CS: next_s.generalOutputPin = next_s.carrierSense;
            default: next_s.generalOutputPin = 1'h0;
        endcase

        // Transmit amplitude
        askTarget = txBit ? `RSQ_PA_FULL : (`RSQ_PA_FULL - s.askDepth);
        levelSum = 9'(s.paLevel) + 9'(s.shapeStep);
        case (s.modFormat)
            `RSQ_FMT_OOK: begin
                next_s.paEnable = txActive && txBit;
                next_s.paLevel = `RSQ_PA_FULL;
            end
            `RSQ_FMT_ASK: begin
                next_s.paEnable = txActive;
                if (s.paLevel < askTarget) begin
                    next_s.paLevel = (levelSum >= 9'(askTarget)) ? askTarget : levelSum[7:0];
                end else if (s.paLevel > askTarget) begin
                    next_s.paLevel = (9'(askTarget) + 9'(s.shapeStep) >= 9'(s.paLevel))
                                     ? askTarget : (s.paLevel - s.shapeStep);
                end
            end
            default: begin
                next_s.paEnable = txActive;
                next_s.paLevel = `RSQ_PA_FULL;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s <= '0;
            s.syncMode <= `RSQ_RST_MODE;
            s.senseBase <= `RSQ_RST_BASE;
            s.levelTarget <= `RSQ_RST_TARGET;
            s.shapeStep <= `RSQ_RST_SHAPE;
            s.absEnable <= 1'h1;
            s.rxState <= RSQ_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign regRdata = s.regRdata;
    assign fifoWrite = s.fifoWrite;
    assign fifoData = s.fifoData;
    assign filterEnable = s.syncFound;
    assign syncFound = s.syncFound;
    assign statusByteValid = s.statusByteValid;
    assign statusByte = s.statusByte;
    assign carrierSense = s.carrierSense;
    assign preambleQualityReached = s.pqReached;
    assign generalOutputPin = s.generalOutputPin;
    assign maxFrontGain = s.frontGain;
    assign maxDigitalGain = s.digitalGain;
    assign channelLevelTarget = s.levelTarget;
    assign paEnable = s.paEnable;
    assign paLevel = s.paLevel;

endmodule

`default_nettype wire

// File: rsq_rx_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Qualifier port checker
// ----------------------------------------
module rsq_rx_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Observed ports
    input wire logic rxActive,
    input wire rsq_pkg::rsq_byte_t rxByte,
    input wire logic rxByteValid,
    input wire logic rawStrengthValid,
    input wire logic payloadDone,
    input wire logic txActive,
    input wire logic fifoWrite,
    input wire rsq_pkg::rsq_byte_t fifoData,
    input wire logic filterEnable,
    input wire logic syncFound,
    input wire logic statusByteValid,
    input wire logic carrierSense,
    input wire logic paEnable
);
    import rsq_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_fifo_pass: assert property (
        rxByteValid && rxActive && syncFound |=> fifoWrite && fifoData == $past(rxByte))
        else $error("qualified byte not passed on");
    a_fifo_block: assert property (
        rxByteValid && !syncFound |=> !fifoWrite)
        else $error("byte written before sync");
    a_filter_gate: assert property (
        filterEnable == syncFound)
        else $error("filtering apart from sync");
    a_sync_cause: assert property (
        $rose(syncFound) |-> $past(rxActive))
        else $error("sync outside receive");
    a_sync_hold: assert property (
        syncFound && !$rose(rxActive) |=> syncFound)
        else $error("sync lost within session");
    a_status_gate: assert property (
        payloadDone && !syncFound |=> !statusByteValid)
        else $error("status byte without packet");
    a_sense_cause: assert property (
        $rose(carrierSense) |-> $past(rawStrengthValid, 2))
        else $error("sense rose without sample");
    a_pa_gate: assert property (
        paEnable |-> $past(txActive))
        else $error("amplifier on outside transmit");
    // Main scenarios reached
    cover property ($rose(syncFound));
    cover property (fifoWrite);
    cover property ($fell(carrierSense));
    cover property (statusByteValid);
endmodule
`default_nettype wire

// File: rsq_air_sender.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Remote sender model
// ----------------------------------------
module rsq_air_sender (
    // Clock
    input wire logic clk_sys,
    // Demodulated stream
    output logic rxBit,
    output logic rxBitStrobe,
    output logic [4:0] syncErr16,
    output logic [5:0] syncErr32,
    // Raw level
    output logic signed [7:0] rawStrength,
    output logic rawStrengthValid
);
    // Quiet lines at time zero
    initial begin
        rxBit = 1'h0;
        rxBitStrobe = 1'h0;
        syncErr16 = 5'h1F;
        syncErr32 = 6'h3F;
        rawStrength = 8'h00;
        rawStrengthValid = 1'h0;
    end
    // One bit; lines scramble once the strobe is gone
    task bitx(input logic b, input logic [4:0] e16, input logic [5:0] e32);
        @(posedge clk_sys);
        rxBit <= b;
        syncErr16 <= e16;
        syncErr32 <= e32;
        rxBitStrobe <= 1'h1;
        @(posedge clk_sys);
        rxBitStrobe <= 1'h0;
        rxBit <= ~b;
        syncErr16 <= ~e16;
        syncErr32 <= ~e32;
    endtask
    // Eight equal samples fill the shortest averaging window
    task level(input logic [7:0] v);
        repeat (8) begin
            @(posedge clk_sys);
            rawStrength <= v;
            rawStrengthValid <= 1'h1;
            @(posedge clk_sys);
            rawStrengthValid <= 1'h0;
            rawStrength <= ~v;
        end
    endtask
endmodule
`default_nettype wire

// File: rsq_rx_signal_qualifiers_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rsq_rx_signal_qualifiers_bench;
    import rsq_pkg::*;
    logic clk_sys = 1'h0, sys_rst = 1'h1, regWrite = 1'h0, regRead = 1'h0, rxActive = 1'h0;
    logic rxByteValid = 1'h0, payloadDone = 1'h0, txActive = 1'h0, txBit = 1'h0, rdPend = 1'h0, b;
    logic rxBit, rxBitStrobe, rawStrengthValid, fifoWrite, filterEnable, syncFound, statusByteValid;
    logic carrierSense, preambleQualityReached, generalOutputPin, paEnable;
    logic [4:0] syncErr16;
    logic [5:0] syncErr32;
    logic signed [7:0] rawStrength;
    rsq_addr_t regAddr = 4'h0;
    rsq_byte_t regWdata = 8'h00, rxByte = 8'h00, regRdata, fifoData, statusByte, paLevel;
    rsq_byte_t rdQ[$], fifoQ[$], stQ[$];
    logic [4:0] e16b[1:3] = '{5'h02, 5'h01, 5'h1F};
    logic [4:0] e16g[1:3] = '{5'h01, 5'h00, 5'h1F};
    logic [5:0] e32b[1:3] = '{6'h3F, 6'h3F, 6'h03};
    logic [5:0] e32g[1:3] = '{6'h3F, 6'h3F, 6'h02};
    int errors = 0, samples_checked = 0;

    rsq_rx_signal_qualifiers i_rsq_rx_signal_qualifiers (.clk_sys, .sys_rst, .regAddr, .regWdata,
        .regWrite, .regRead, .regRdata, .rxActive, .rxBit, .rxBitStrobe, .syncErr16, .syncErr32,
        .rawStrength, .rawStrengthValid, .rxByte, .rxByteValid, .payloadDone, .fifoWrite, .fifoData,
        .filterEnable, .syncFound, .statusByteValid, .statusByte, .carrierSense, .preambleQualityReached,
        .generalOutputPin, .maxFrontGain(), .maxDigitalGain(), .channelLevelTarget(), .txActive,
        .txBit, .paEnable, .paLevel);
    rsq_air_sender i_rsq_air_sender (.clk_sys, .rxBit, .rxBitStrobe, .syncErr16, .syncErr32,
        .rawStrength, .rawStrengthValid);

    // ----------------------------------------
    // Clock, compare and bus tasks
    // ----------------------------------------
    always #12.5 clk_sys = ~clk_sys;
    task finish_test;
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task eq(input string n, input rsq_byte_t e, input rsq_byte_t g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bit1(input string n, input logic e, ref logic g);
        @(negedge clk_sys);
        eq(n, {7'h00, e}, {7'h00, g});
    endtask
    function automatic rsq_byte_t pop(ref rsq_byte_t q[$]);
        return q.size() ? q.pop_front() : 8'hXX;
    endfunction
    task wr(input rsq_addr_t a, input rsq_byte_t d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge clk_sys);
        regWrite <= 1'h0;
    endtask
    task rd(input rsq_addr_t a, input rsq_byte_t e);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'h1;
        rdQ.push_back(e);
        @(posedge clk_sys);
        regRead <= 1'h0;
    endtask
    // Demodulator byte, noted if it must pass
    task rxb(input logic k);
        rsq_byte_t d;
        d = 8'($urandom);
        @(posedge clk_sys);
        rxByte <= d;
        rxByteValid <= 1'h1;
        if (k) fifoQ.push_back(d);
        @(posedge clk_sys);
        rxByteValid <= 1'h0;
    endtask
    task ses;
        @(posedge clk_sys);
        rxActive <= 1'h0;
        @(posedge clk_sys);
        rxActive <= 1'h1;
    endtask
    task lv(input rsq_byte_t v);
        i_rsq_air_sender.level(v);
        repeat (2) @(posedge clk_sys);
    endtask
    task tg(input logic [4:0] e);
        i_rsq_air_sender.bitx(~b, e, 6'h3F);
        b = ~b;
    endtask

    // Results are matched against the oldest note
    always @(negedge clk_sys) begin
        if (rdPend) eq("rdata", pop(rdQ), regRdata);
        if (fifoWrite) eq("fifo", pop(fifoQ), fifoData);
        if (statusByteValid) eq("status", pop(stQ), statusByte);
        rdPend = regRead;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        finish_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(64));
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'h0;
        rd(4'h0, 8'h02);
        rd(4'h1, 8'h40);
        rd(4'h4, 8'hC0);
        rd(4'hF, 8'h00);
        wr(4'h0, 8'h00);
        ses();
        repeat (3) @(posedge clk_sys);
        bit1("sync", 1'h1, syncFound);
        // Match boundaries, one refused and one accepted per mode
        for (int m = 1; m < 4; m++) begin
            wr(4'h0, 8'(m));
            ses();
            i_rsq_air_sender.bitx(1'h0, e16b[m], e32b[m]);
            bit1("sync", 1'h0, syncFound);
            rxb(1'h0);
            i_rsq_air_sender.bitx(1'h1, e16g[m], e32g[m]);
            bit1("sync", 1'h1, syncFound);
            rxb(1'h1);
        end
        // Preamble quality gate at threshold one
        wr(4'h0, 8'h11);
        wr(4'h8, 8'h08);
        ses();
        b = 1'h0;
        i_rsq_air_sender.bitx(b, 5'h1F, 6'h3F);
        repeat (2) tg(5'h1F);
        tg(5'h00);
        bit1("sync", 1'h0, syncFound);
        repeat (2) tg(5'h1F);
        rd(4'hB, 8'h05);
        rd(4'h9, 8'h20);
        bit1("pin", 1'h1, generalOutputPin);
        i_rsq_air_sender.bitx(b, 5'h1F, 6'h3F);
        rd(4'hB, 8'h00);
        repeat (5) tg(5'h1F);
        tg(5'h00);
        bit1("sync", 1'h1, syncFound);
        // Sense-qualified search, frozen strength and status byte
        wr(4'h0, 8'h85);
        wr(4'h8, 8'h0E);
        ses();
        lv(8'h9C);
        i_rsq_air_sender.bitx(1'h1, 5'h00, 6'h3F);
        bit1("sync", 1'h0, syncFound);
        lv(8'hD8);
        rd(4'hA, 8'hD8);
        rd(4'h9, 8'h40);
        bit1("pin", 1'h1, generalOutputPin);
        i_rsq_air_sender.bitx(1'h0, 5'h00, 6'h3F);
        bit1("sync", 1'h1, syncFound);
        lv(8'hE0);
        rd(4'hA, 8'hD8);
        @(posedge clk_sys);
        payloadDone <= 1'h1;
        stQ.push_back(8'hE0);
        @(posedge clk_sys);
        payloadDone <= 1'h0;
        ses();
        lv(8'hF0);
        rd(4'hA, 8'hF0);
        // Offset moves the absolute threshold
        wr(4'h1, 8'h47);
        lv(8'hC8);
        bit1("cs", 1'h0, carrierSense);
        wr(4'h1, 8'h40);
        lv(8'hC8);
        bit1("cs", 1'h1, carrierSense);
        // Relative steps of six dB
        wr(4'h1, 8'h10);
        lv(8'hA0);
        bit1("cs", 1'h0, carrierSense);
        lv(8'hB0);
        bit1("cs", 1'h1, carrierSense);
        lv(8'hB4);
        bit1("cs", 1'h1, carrierSense);
        // On-off keying follows the data
        wr(4'h5, 8'h01);
        txActive <= 1'h1;
        repeat (6) begin
            @(posedge clk_sys);
            txBit <= 1'($urandom);
            @(posedge clk_sys);
            bit1("pa", txBit, paEnable);
        end
        eq("level", 8'hFF, paLevel);
        finish_test();
    end
endmodule
bind rsq_rx_signal_qualifiers rsq_rx_checker i_rsq_rx_checker (.clk_sys, .sys_rst, .rxActive, .rxByte,
    .rxByteValid, .rawStrengthValid, .payloadDone, .txActive, .fifoWrite, .fifoData, .filterEnable,
    .syncFound, .statusByteValid, .carrierSense, .paEnable);
`default_nettype wire
